/* pkg/lims_regs.vh */
// register map, field positions, reset values and timing constants for the link indicator block
`ifndef LIMS_REGS_VH
`define LIMS_REGS_VH

// ****************************************************
// register offsets (byte addresses)
// ****************************************************
`define LIMS_ADDR_W            4
`define LIMS_OFS_CTRL          4'h0
`define LIMS_OFS_LINK          4'h4
`define LIMS_OFS_STAT          4'h8

// ****************************************************
// control register fields
// ****************************************************
`define LIMS_CTRL_LOWFREQ_BIT  0
`define LIMS_CTRL_RST          32'h0000_0000

// ****************************************************
// link register fields
// ****************************************************
`define LIMS_LINK_UP_BIT       0
`define LIMS_LINK_FAST_BIT     1
`define LIMS_LINK_FULL_BIT     2
`define LIMS_LINK_RST          32'h0000_0000

// ****************************************************
// status register fields
// ****************************************************
`define LIMS_STAT_SPI_BIT      0
`define LIMS_STAT_PAR_BIT      1
`define LIMS_STAT_LOWFREQ_BIT  2
`define LIMS_STAT_STRAP_LSB    4
`define LIMS_STAT_STRAP_MSB    7

// ****************************************************
// strap codes
// ****************************************************
`define LIMS_STRAP_SPI         4'h0
`define LIMS_STRAP_PAR_MASK    4'hE
`define LIMS_STRAP_PAR         4'h4

// ****************************************************
// timing
// ****************************************************
`define LIMS_REF_MHZ           7'h19
`define LIMS_FAST_MHZ          7'h64
`define LIMS_CLK_RST           7'h00
`define LIMS_MCLK_HZ           10000000
`define LIMS_MS_DIV            1000
`define LIMS_BLINK_MS          50

// ****************************************************
// bus read data
// ****************************************************
`define LIMS_RDATA_RST         32'h0000_0000

// ****************************************************
// host mode flag positions
// ****************************************************
`define LIMS_MODE_SPI          0
`define LIMS_MODE_PAR          1

// ****************************************************
// synchroniser bit positions
// ****************************************************
`define LIMS_SYNC_W            8
`define LIMS_SYN_STRAP_LSB     0
`define LIMS_SYN_STRAP_MSB     3
`define LIMS_SYN_TX            4
`define LIMS_SYN_RX            5
`define LIMS_SYN_COL           6
`define LIMS_SYN_RST           7

`endif

/* core/lims_top.v */
// link indicator leds, host mode strap decode and internal clock select
// What this block does
// - strap 0000 picks serial host mode, 010x picks parallel bus host mode
// - internal clock runs 25 MHz in low frequency mode or 100 MHz normally
// - link, speed, duplex leds active low: up, 100 Mbps, full duplex
// - link up: activity led steady without traffic, flashing during traffic
// - link down: activity led held high regardless of traffic
// - collision led low on collision during transmit, high otherwise
//
// Implementation choices: the address map and register access over Avalon-MM.
`include "lims_regs.vh"
module lims_top #(
    parameter integer BLINK_CYCLES = (`LIMS_MCLK_HZ / `LIMS_MS_DIV) * `LIMS_BLINK_MS
) (
    input  wire        mclk,
    input  wire        reset,
    input  wire [3:0]  host_mode_strap,
    input  wire        tx_active,
    input  wire        rx_active,
    input  wire        collision,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg         link_up_led_n,
    output reg         speed_fast_led_n,
    output reg         full_duplex_led_n,
    output reg         traffic_activity_led_n,
    output reg         collision_led_n,
    output reg         spi_mode_sel,
    output reg         parallel_mode_sel,
    output reg  [6:0]  int_clk_mhz
);

    // ****************************************************
    // bus states and synchroniser width
    // ****************************************************
    localparam [1:0]   BUS_IDLE = 2'h1;
    localparam [1:0]   BUS_ACK  = 2'h2;
    localparam integer SYNC_W   = `LIMS_SYNC_W;

    // ****************************************************
    // decode helpers
    // ****************************************************
    // strap code to host mode flags, other codes select none
    function [1:0] strap_mode;
        input [3:0] code;
        begin
            strap_mode = 2'h0;
            if (code == `LIMS_STRAP_SPI) begin
                strap_mode[`LIMS_MODE_SPI] = 1'b1;
            end
            if ((code & `LIMS_STRAP_PAR_MASK) == `LIMS_STRAP_PAR) begin
                strap_mode[`LIMS_MODE_PAR] = 1'b1;
            end
        end
    endfunction

    // register select for a bus address
    function addr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // ****************************************************
    // input synchronisers
    // ****************************************************
    // no reset on these flops, so the strap is still seen while reset is high
    wire [SYNC_W-1:0] sync_in;
    wire [SYNC_W-1:0] sync_q;

    assign sync_in[`LIMS_SYN_STRAP_MSB:`LIMS_SYN_STRAP_LSB] = host_mode_strap;
    assign sync_in[`LIMS_SYN_TX]                            = tx_active;
    assign sync_in[`LIMS_SYN_RX]                            = rx_active;
    assign sync_in[`LIMS_SYN_COL]                           = collision;
    assign sync_in[`LIMS_SYN_RST]                           = reset;

    genvar g;
    generate
        for (g = 0; g < SYNC_W; g = g + 1) begin : g_sync
            reg s1_r;
            reg s2_r;
            always @(posedge mclk) begin
                s1_r <= sync_in[g];
                s2_r <= s1_r;
            end
            assign sync_q[g] = s2_r;
        end
    endgenerate

    wire [3:0] strap_q = sync_q[`LIMS_SYN_STRAP_MSB:`LIMS_SYN_STRAP_LSB];
    wire       rst_q   = sync_q[`LIMS_SYN_RST];
    wire       traffic = sync_q[`LIMS_SYN_TX] | sync_q[`LIMS_SYN_RX];
    wire       col_tx  = sync_q[`LIMS_SYN_COL] & sync_q[`LIMS_SYN_TX];

    // ****************************************************
    // strap capture
    // ****************************************************
    reg  [3:0] strap_r;
    wire [1:0] host_mode = strap_mode(strap_r);
    wire       mode_ok   = ~rst_q;

    // loads while the synchronised reset is high, then holds until the next reset
    always @(posedge mclk) begin
        if (rst_q) begin
            strap_r <= strap_q;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    reg  [1:0]  bus_st_r;
    reg  [1:0]  bus_nxt;
    reg  [31:0] ctrl_r;
    reg  [31:0] link_r;
    reg  [31:0] ctrl_nxt;
    reg  [31:0] link_nxt;
    reg  [31:0] rd_nxt;
    wire        wr_done = avs_write & (bus_st_r == BUS_ACK);
    wire        lowf    = ctrl_r[`LIMS_CTRL_LOWFREQ_BIT];
    wire        lup     = link_r[`LIMS_LINK_UP_BIT];
    wire [`LIMS_LINK_FULL_BIT:`LIMS_LINK_UP_BIT] link_wd = avs_writedata[`LIMS_LINK_FULL_BIT:`LIMS_LINK_UP_BIT];

    always @* begin
        rd_nxt = `LIMS_RDATA_RST;
        case (avs_address)
            `LIMS_OFS_CTRL: begin
                rd_nxt = ctrl_r;
            end
            `LIMS_OFS_LINK: begin
                rd_nxt = link_r;
            end
            `LIMS_OFS_STAT: begin
                rd_nxt[`LIMS_STAT_SPI_BIT]                        = host_mode[`LIMS_MODE_SPI] & mode_ok;
                rd_nxt[`LIMS_STAT_PAR_BIT]                        = host_mode[`LIMS_MODE_PAR] & mode_ok;
                rd_nxt[`LIMS_STAT_LOWFREQ_BIT]                    = lowf;
                rd_nxt[`LIMS_STAT_STRAP_MSB:`LIMS_STAT_STRAP_LSB] = strap_r;
            end
            default: begin
                rd_nxt = `LIMS_RDATA_RST;
            end
        endcase
    end

    // writes land at the completing edge; only defined bits are kept
    always @* begin
        ctrl_nxt = ctrl_r;
        link_nxt = link_r;
        if (wr_done && addr_hit(avs_address, `LIMS_OFS_CTRL)) begin
            ctrl_nxt                         = `LIMS_CTRL_RST;
            ctrl_nxt[`LIMS_CTRL_LOWFREQ_BIT] = avs_writedata[`LIMS_CTRL_LOWFREQ_BIT];
        end
        if (wr_done && addr_hit(avs_address, `LIMS_OFS_LINK)) begin
            link_nxt                                        = `LIMS_LINK_RST;
            link_nxt[`LIMS_LINK_FULL_BIT:`LIMS_LINK_UP_BIT] = link_wd;
        end
    end

    // one wait cycle: taken in idle, waitrequest low on the next edge
    always @* begin
        bus_nxt = BUS_IDLE;
        case (bus_st_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_nxt = BUS_ACK;
                end
            end
            BUS_ACK: begin
                bus_nxt = BUS_IDLE;
            end
            default: begin
                bus_nxt = BUS_IDLE;
            end
        endcase
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_st_r        <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `LIMS_RDATA_RST;
            ctrl_r          <= `LIMS_CTRL_RST;
            link_r          <= `LIMS_LINK_RST;
        end else begin
            bus_st_r        <= bus_nxt;
            avs_waitrequest <= (bus_nxt != BUS_ACK);
            ctrl_r          <= ctrl_nxt;
            link_r          <= link_nxt;
            if (bus_nxt == BUS_ACK) begin
                avs_readdata <= avs_read ? rd_nxt : `LIMS_RDATA_RST;
            end
        end
    end

    // ****************************************************
    // activity blink timer
    // ****************************************************
    reg  [31:0] blink_cnt_r;
    reg         blink_r;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_r     <= 1'b0;
        end else if (!traffic || !lup) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_r     <= 1'b0;
        end else if (blink_cnt_r >= BLINK_CYCLES - 1) begin
            blink_cnt_r <= 32'h0000_0000;
            blink_r     <= ~blink_r;
        end else begin
            blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            link_up_led_n          <= 1'b1;
            speed_fast_led_n       <= 1'b1;
            full_duplex_led_n      <= 1'b1;
            traffic_activity_led_n <= 1'b1;
            collision_led_n        <= 1'b1;
            spi_mode_sel           <= 1'b0;
            parallel_mode_sel      <= 1'b0;
            int_clk_mhz            <= `LIMS_CLK_RST;
        end else begin
            link_up_led_n          <= ~lup;
            speed_fast_led_n       <= ~link_r[`LIMS_LINK_FAST_BIT];
            full_duplex_led_n      <= ~link_r[`LIMS_LINK_FULL_BIT];
            traffic_activity_led_n <= lup ? blink_r : 1'b1;
            collision_led_n        <= ~col_tx;
            spi_mode_sel           <= host_mode[`LIMS_MODE_SPI] & mode_ok;
            parallel_mode_sel      <= host_mode[`LIMS_MODE_PAR] & mode_ok;
            int_clk_mhz            <= lowf ? `LIMS_REF_MHZ : `LIMS_FAST_MHZ;
        end
    end

endmodule

/* bench/lims_board.sv */
// board side: strap pins with pull-downs
module lims_board (
    input  wire logic       drive_en,
    input  wire logic [3:0] code,
    output wire logic [3:0] host_mode_strap
);
    timeunit 1ns;
    timeprecision 1ns;
    // released straps read low through the pull-downs
    assign host_mode_strap = drive_en ? code : 4'h0;
endmodule

/* bench/lims_checker.sv */
// port assertions for the link indicator block
module lims_checker (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        tx_active,
    input wire logic        rx_active,
    input wire logic        collision,
    input wire logic        link_up_led_n,
    input wire logic        speed_fast_led_n,
    input wire logic        full_duplex_led_n,
    input wire logic        traffic_activity_led_n,
    input wire logic        collision_led_n,
    input wire logic        spi_mode_sel,
    input wire logic        parallel_mode_sel,
    input wire logic [6:0]  int_clk_mhz
);
    logic [2:0] cyc_r;
    logic [2:0] lk_r;
    logic       lf_r;
    logic       wr_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    // shadow of the last written control and link values
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            {cyc_r, lk_r, lf_r, wr_r} <= 8'h00;
        end else begin
            if (cyc_r != 3'h7) cyc_r <= cyc_r + 3'h1;
            wr_r <= avs_write && !avs_waitrequest;
            if (avs_write && !avs_waitrequest && avs_address == 4'h0) lf_r <= avs_writedata[0];
            if (avs_write && !avs_waitrequest && avs_address == 4'h4) lk_r <= avs_writedata[2:0];
        end
    end
    property p_one_mode; spi_mode_sel |-> !parallel_mode_sel; endproperty
    a_one_mode: assert property (p_one_mode) else $error("both host modes selected");
    property p_mode_held; cyc_r == 3'h7 |-> $stable({spi_mode_sel, parallel_mode_sel}); endproperty
    a_mode_held: assert property (p_mode_held) else $error("host mode changed");
    property p_clk; cyc_r == 3'h7 && !wr_r && !$past(wr_r) |-> int_clk_mhz == (lf_r ? 7'h19 : 7'h64); endproperty
    a_clk: assert property (p_clk) else $error("internal clock rate wrong");
    property p_leds; cyc_r == 3'h7 && !wr_r && !$past(wr_r) |->
        {full_duplex_led_n, speed_fast_led_n, link_up_led_n} == ~lk_r; endproperty
    a_leds: assert property (p_leds) else $error("link leds wrong");
    property p_act_idle; (!tx_active && !rx_active && !link_up_led_n) [*6] |-> !traffic_activity_led_n; endproperty
    a_act_idle: assert property (p_act_idle) else $error("activity led not steady");
    property p_act_down; link_up_led_n [*3] |-> traffic_activity_led_n; endproperty
    a_act_down: assert property (p_act_down) else $error("activity led low with link down");
    property p_col_on; (collision && tx_active) [*4] |-> !collision_led_n; endproperty
    a_col_on: assert property (p_col_on) else $error("collision led not lit");
    property p_col_off; (!collision) [*4] |-> collision_led_n; endproperty
    a_col_off: assert property (p_col_off) else $error("collision led lit");
    cover property (wr_r && lf_r);
    cover property (parallel_mode_sel);
    cover property (!collision_led_n);
endmodule
bind lims_top lims_checker i_chk (.mclk, .reset, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
    .tx_active, .rx_active, .collision, .link_up_led_n, .speed_fast_led_n, .full_duplex_led_n,
    .traffic_activity_led_n, .collision_led_n, .spi_mode_sel, .parallel_mode_sel, .int_clk_mhz);

/* bench/link_indicator_and_mode_select_test.sv */
// testbench: strap decode, clock select, leds and register access
module link_indicator_and_mode_select_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, reset, drive_en, tx_active, rx_active, collision, avs_read, avs_write, avs_waitrequest;
    logic        link_up_led_n, speed_fast_led_n, full_duplex_led_n, traffic_activity_led_n, collision_led_n;
    logic        spi_mode_sel, parallel_mode_sel;
    logic [3:0]  code, avs_address;
    logic [6:0]  int_clk_mhz;
    logic [31:0] avs_writedata, avs_readdata, d;
    wire  [3:0]  host_mode_strap;
    logic [31:0] q[$];
    int          num_errors, check_count, i, n, seed;
    lims_board i_board (.drive_en, .code, .host_mode_strap);
    lims_top #(.BLINK_CYCLES(4)) i_dut (.mclk, .reset, .host_mode_strap, .tx_active, .rx_active, .collision,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .link_up_led_n,
        .speed_fast_led_n, .full_duplex_led_n, .traffic_activity_led_n, .collision_led_n, .spi_mode_sel,
        .parallel_mode_sel, .int_clk_mhz);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        int k;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= v;
        {avs_write, avs_read} <= {w, !w};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        {avs_write, avs_read} <= 2'b00;
        if (k >= 50) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic steady(input logic e);
        repeat (8) begin
            @(negedge mclk);
            check("activity", traffic_activity_led_n, e);
        end
    endtask
    // read results checked against the oldest note
    always @(posedge mclk) begin
        if (avs_read && avs_waitrequest === 1'b0) check("readdata", avs_readdata, q.pop_front());
    end
    initial begin
        repeat (100000) @(posedge mclk);
        num_errors++;
        conclude();
    end
    initial begin
        seed = 32'h02d6_2b34;
        {reset, drive_en, code, tx_active, rx_active, collision} = 9'h180;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        repeat (20) @(posedge mclk);
        for (i = 0; i < 17; i++) begin
            reset <= 1'b0;
            repeat (5) @(posedge mclk);
            drive_en <= (i == 16);
            repeat (2) @(negedge mclk);
            check("spi_sel", spi_mode_sel, i % 16 == 0);
            check("par_sel", parallel_mode_sel, (i & 14) == 4);
            rd(4'h8, {24'h00_0000, i[3:0], 2'b00, (i & 14) == 4, i % 16 == 0});
            if (i < 16) begin
                {reset, drive_en, code} <= {2'b11, code + 4'h1};
                repeat (2) @(posedge mclk);
            end
        end
        bus(1'b1, 4'h0, 32'hffff_ffff);
        repeat (3) @(negedge mclk);
        check("clk_low", int_clk_mhz, 7'h19);
        rd(4'h0, 32'h0000_0001);
        bus(1'b1, 4'h8, 32'h0000_0000);
        bus(1'b1, 4'hc, 32'hffff_ffff);
        rd(4'hc, 32'h0000_0000);
        rd(4'h8, 32'h0000_0005);
        bus(1'b1, 4'h0, 32'h0000_0000);
        repeat (3) @(negedge mclk);
        check("clk_fast", int_clk_mhz, 7'h64);
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            bus(1'b1, 4'h4, {d[31:3], i[2:0]});
            {tx_active, rx_active, collision} <= d[5:3];
            repeat (3) @(negedge mclk);
            check("leds", {full_duplex_led_n, speed_fast_led_n, link_up_led_n}, i[2:0] ^ 3'h7);
            rd(4'h4, i);
        end
        @(posedge mclk);
        {tx_active, rx_active, collision} <= 3'h0;
        repeat (8) @(negedge mclk);
        steady(1'b0);
        @(posedge mclk);
        rx_active <= 1'b1;
        n = 0;
        d[0] = traffic_activity_led_n;
        repeat (24) begin
            @(negedge mclk);
            n += (traffic_activity_led_n !== d[0]);
            d[0] = traffic_activity_led_n;
        end
        check("act_flash", n >= 3 && n <= 7, 1'b1);
        @(posedge mclk);
        {tx_active, collision} <= 2'b11;
        repeat (5) @(negedge mclk);
        check("col_on", collision_led_n, 1'b0);
        @(posedge mclk);
        collision <= 1'b0;
        repeat (5) @(negedge mclk);
        check("col_off", collision_led_n, 1'b1);
        bus(1'b1, 4'h4, 32'h0000_0000);
        repeat (4) @(negedge mclk);
        steady(1'b1);
        conclude();
    end
endmodule
